// >>> scbr_defines.svh
`ifndef SCBR_DEFINES_SVH
`define SCBR_DEFINES_SVH

// Array geometry: one bit wide, smallest documented depth
`define SCBR_ADDR_W        16
`define SCBR_DEPTH         65536
`define SCBR_ADDR_MAX      16'hFFFF

// Write-guarded blocks: first block ends at GUARD1_END, second at GUARD2_END
`define SCBR_GUARD1_END    16'h4000
`define SCBR_GUARD2_END    16'h8000

// Polarity bytes: all four at this value select reset-high, anything else reset-low
`define SCBR_POL_HIGH_BYTE 8'h00
`define SCBR_POL_BYTES     4

// Power-up reset time and clock period
`define SCBR_POR_NS        1000
`define SCBR_CLK_NS        25

// Input synchroniser lanes
`define SCBR_SYNC_W        8
`define SCBR_SY_FPGA_CONFIG_CLOCK       0
`define SCBR_SY_CS         1
`define SCBR_SY_RSTOE      2
`define SCBR_SY_PSEL       3
`define SCBR_SY_G1         4
`define SCBR_SY_G2         5
`define SCBR_SY_DSEL       6
`define SCBR_SY_DATA       7

`endif

// >>> scbr_pkg.sv
`default_nettype none
`include "scbr_defines.svh"

package scbr_pkg;
  typedef logic [`SCBR_ADDR_W-1:0] scbr_addr_t;
  typedef logic [`SCBR_POL_BYTES*8-1:0] scbr_pol_t;
  typedef enum {
    ST_POWERUP,
    ST_READ,
    ST_EXHAUSTED,
    ST_PROG
  } scbr_state_e;
endpackage : scbr_pkg

`default_nettype wire

// >>> scbr_mem_if.sv
`default_nettype none
`include "scbr_defines.svh"

interface scbr_mem_if;
  logic [`SCBR_ADDR_W-1:0] addr;
  logic                    wr_en;
  logic                    wr_bit;
  logic                    rd_bit;
  modport ctrl (output addr, output wr_en, output wr_bit, input rd_bit);
  modport mem  (input addr, input wr_en, input wr_bit, output rd_bit);
endinterface : scbr_mem_if

`default_nettype wire

// >>> scbr_bit_array.sv
`default_nettype none
`include "scbr_defines.svh"

module scbr_bit_array (
  input  wire logic clk,
  scbr_mem_if.mem   port
);
  import scbr_pkg::*;

  logic [`SCBR_DEPTH-1:0] bits_reg;

  // One bit per address, written on a single-cycle strobe
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      bits_reg[port.addr] <= port.wr_bit;
    end
  end

  assign port.rd_bit = bits_reg[port.addr];
endmodule : scbr_bit_array

`default_nettype wire

// >>> scbr_reader.sv
`default_nettype none
`include "scbr_defines.svh"

// Behaviour
// (RULE_01) Reset level clears counter, floats data
// (RULE_02) Chip select high: halted, data floating
// (RULE_03) Reset level wins regardless of chip select
// (RULE_04) Array exhausted: float data pin
// (RULE_05) Power-up clears address counter automatically
// (RULE_06) Each clock advances counter, read or program
// (RULE_07) Program mode: reset clears; enable drives output
// (RULE_08) Reset polarity chosen by four bytes
// (RULE_09) Guard high blocks writes to lowest block
// (RULE_10) Block guards ignored during read-out
// (RULE_11) Counting needs chip select and enable
// (RULE_12) Chip select high stops counters, standby
// (RULE_13) Program mode ignores chip select
// (RULE_14) Cascade-out low at counter maximum
// (RULE_15) Cascade-out follows chip select until reset
// (RULE_16) Device select acts only in program mode
// (RULE_17) Ready held low during power-up reset
// (RULE_18) Data three-state on read, open-collector programming
// (RULE_19) Array one bit wide, read serially
// (RULE_20) Program mode entered with select low
// (RULE_21) Present addressed bit, step on rising clock
module scbr_reader (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire logic           fpga_config_clock,
  input  wire logic           chip_sel_n,
  input  wire logic           reset_oe,
  input  wire logic           program_mode_select_n,
  input  wire logic           block_guard_first,
  input  wire logic           block_guard_second,
  input  wire logic           device_select_bit,
  input  wire scbr_pkg::scbr_pol_t polarity_bytes,
  input  wire logic           data_in,
  output var  logic           data_out,
  output var  logic           data_oe,
  output var  logic           cascade_out_low,
  output var  logic           ready_out,
  output var  logic           ready_oe,
  output var  logic           standby,
  output var  scbr_pkg::scbr_addr_t bit_index
);
  import scbr_pkg::*;

  localparam int POR_CYCLES = (`SCBR_POR_NS + `SCBR_CLK_NS - 1) / `SCBR_CLK_NS;

  logic [`SCBR_SYNC_W-1:0] sync1_reg;
  logic [`SCBR_SYNC_W-1:0] sync2_reg;
  logic [`SCBR_SYNC_W-1:0] pin_raw;
  logic                    fpga_config_clock_prev_reg;
  logic                    fpga_config_clock_rise;
  logic                    cs_s;
  logic                    rstoe_s;
  logic                    prog_mode;
  logic                    pol_reset_high;
  logic                    reset_lvl;
  logic                    read_step;
  logic                    prog_step;
  logic                    step;
  logic                    guarded;
  logic                    at_max;
  logic [7:0]              por_cnt_reg;
  scbr_state_e             state_reg;
  scbr_state_e             state_next;
  scbr_addr_t              addr_reg;
  scbr_addr_t              addr_next;

  scbr_mem_if mem_bus ();

  scbr_bit_array u_array (
    .clk  (clk),
    .port (mem_bus.mem)
  );

  // Two-stage synchroniser for every pin input
  assign pin_raw = {data_in, device_select_bit, block_guard_second, block_guard_first,
                    program_mode_select_n, reset_oe, chip_sel_n, fpga_config_clock};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else if (clk_en) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fpga_config_clock_prev_reg <= 1'b0;
    end else if (clk_en) begin
      fpga_config_clock_prev_reg <= sync2_reg[`SCBR_SY_FPGA_CONFIG_CLOCK];
    end
  end

  assign fpga_config_clock_rise = sync2_reg[`SCBR_SY_FPGA_CONFIG_CLOCK] & ~fpga_config_clock_prev_reg;
  assign cs_s      = sync2_reg[`SCBR_SY_CS];
  assign rstoe_s   = sync2_reg[`SCBR_SY_RSTOE];
  assign prog_mode = ~sync2_reg[`SCBR_SY_PSEL];  // [RULE_20]

  // Reset polarity from the configuration bytes
  assign pol_reset_high = (polarity_bytes == {`SCBR_POL_BYTES{`SCBR_POL_HIGH_BYTE}});  // [RULE_08]
  assign reset_lvl      = pol_reset_high ? rstoe_s : ~rstoe_s;  // [RULE_08]

  assign at_max = (addr_reg == `SCBR_ADDR_MAX);

  // Guards only matter in program mode: they gate writes and the data pin pull-down
  assign guarded = (sync2_reg[`SCBR_SY_G1] && addr_reg < `SCBR_GUARD1_END) ||
                   (sync2_reg[`SCBR_SY_G2] && addr_reg >= `SCBR_GUARD1_END &&
                    addr_reg < `SCBR_GUARD2_END);  // [RULE_09] [RULE_10]

  // Counting enables
  assign read_step = (state_reg == ST_READ) && !prog_mode && !cs_s && !reset_lvl && fpga_config_clock_rise;  // [RULE_11] [RULE_12]
  assign prog_step = (state_reg == ST_PROG) && sync2_reg[`SCBR_SY_DSEL] && !reset_lvl &&
                     fpga_config_clock_rise;  // [RULE_13] [RULE_16]
  assign step      = read_step | prog_step;  // [RULE_06]

  // Power-up reset timer
  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt_reg <= 8'h00;
    end else if (clk_en && state_reg == ST_POWERUP) begin
      por_cnt_reg <= por_cnt_reg + 8'h01;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POWERUP: begin
        if (por_cnt_reg == 8'(POR_CYCLES - 1)) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (prog_mode) begin
          state_next = ST_PROG;
        end else if (read_step && at_max) begin
          state_next = ST_EXHAUSTED;  // [RULE_14]
        end
      end
      ST_EXHAUSTED: begin
        if (prog_mode) begin
          state_next = ST_PROG;
        end else if (reset_lvl) begin
          state_next = ST_READ;  // [RULE_15]
        end
      end
      ST_PROG: begin
        if (!prog_mode) begin
          state_next = ST_READ;
        end
      end
      default: begin
        state_next = ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_POWERUP;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Address and bit counter
  always_comb begin
    addr_next = addr_reg;
    if (state_reg == ST_POWERUP || reset_lvl) begin
      addr_next = '0;  // [RULE_01] [RULE_03] [RULE_05] [RULE_07]
    end else if (state_next != state_reg && (state_next == ST_PROG || state_reg == ST_PROG)) begin
      addr_next = '0;
    end else if (step && !(read_step && at_max)) begin
      addr_next = addr_reg + 16'h0001;  // [RULE_06] [RULE_21]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg <= '0;  // [RULE_05]
    end else if (clk_en) begin
      addr_reg <= addr_next;
    end
  end

  // Memory port: writes on each programming step to an unguarded address
  assign mem_bus.addr   = addr_reg;  // [RULE_19]
  assign mem_bus.wr_bit = sync2_reg[`SCBR_SY_DATA];
  assign mem_bus.wr_en  = clk_en && prog_step && !guarded;  // [RULE_09]

  // Data pin driver
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else if (clk_en) begin
      if (state_next == ST_READ && !prog_mode && !cs_s && !reset_lvl) begin
        data_out <= mem_bus.rd_bit;  // [RULE_21] [RULE_18]
        data_oe  <= 1'b1;  // [RULE_11]
      end else if (state_reg == ST_PROG && prog_mode && sync2_reg[`SCBR_SY_DSEL] && !reset_lvl && guarded) begin
        data_out <= 1'b0;  // [RULE_18]
        data_oe  <= ~mem_bus.rd_bit;
      end else begin
        data_out <= 1'b0;
        data_oe  <= 1'b0;  // [RULE_01] [RULE_02] [RULE_04]
      end
    end
  end

  // Cascade-out and standby
  always_ff @(posedge clk) begin
    if (rst) begin
      cascade_out_low <= 1'b1;
      standby         <= 1'b0;
    end else if (clk_en) begin
      cascade_out_low <= !(state_next == ST_EXHAUSTED) || cs_s;  // [RULE_14] [RULE_15]
      standby         <= !prog_mode && cs_s;  // [RULE_12]
    end
  end

  // Open-collector ready pin: pulled low during power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_oe <= 1'b1;
    end else if (clk_en) begin
      ready_oe <= (state_next == ST_POWERUP);  // [RULE_17]
    end
  end

  assign ready_out = 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_index <= '0;
    end else if (clk_en) begin
      bit_index <= addr_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !clk_en);

  sequence s_last_bit;
    read_step && at_max;
  endsequence

  sequence s_reading_selected;
    !cs_s && !reset_lvl && !prog_mode;
  endsequence

  AST_RESET_FLOATS: assert property (  // [RULE_01]
      (reset_lvl && state_reg != ST_POWERUP) |=> (addr_reg == 16'h0000 && !data_oe))
    else $error("reset level did not clear counter and float data");

  AST_CS_HIGH_HALTS: assert property (  // [RULE_02]
      (!prog_mode && cs_s && !reset_lvl && state_reg == ST_READ) |=> ($stable(addr_reg) && !data_oe))
    else $error("counter moved or data driven with chip select high");

  AST_RESET_OVER_CS: assert property ((reset_lvl && !cs_s && state_reg != ST_POWERUP) |=> !data_oe)  // [RULE_03]
    else $error("reset level with chip select low did not float data");

  AST_EXHAUST_FLOAT: assert property (s_last_bit |=> ##1 !data_oe)  // [RULE_04]
    else $error("data still driven after last bit");

  AST_POWERUP_CLEAR: assert property ((state_reg == ST_POWERUP) |-> (addr_reg == 16'h0000 && !data_oe))  // [RULE_05]
    else $error("counter not clear during power-up");

  AST_STEP_ADVANCE: assert property (  // [RULE_06]
      (step && !at_max && !reset_lvl && state_next == state_reg) |=>
      (addr_reg == $past(addr_reg) + 16'h0001))
    else $error("clock edge did not advance counter");

  AST_PROG_IGNORES_CS: assert property (  // [RULE_13]
      (state_reg == ST_PROG && prog_mode && sync2_reg[`SCBR_SY_DSEL] && fpga_config_clock_rise && !reset_lvl && !at_max) |=>
      (addr_reg == $past(addr_reg) + 16'h0001))
    else $error("programming step blocked");

  AST_CASCADE_LOW: assert property ((s_last_bit ##1 s_reading_selected) |=> !cascade_out_low)  // [RULE_14]
    else $error("cascade-out not low after last bit");

  AST_GUARD_BLOCKS: assert property (mem_bus.wr_en |-> (prog_mode && !guarded))  // [RULE_09]
    else $error("write reached a guarded block or outside program mode");

  AST_READY_POR: assert property ((state_reg == ST_POWERUP && state_next == ST_POWERUP) |=> ready_oe)  // [RULE_17]
    else $error("ready released during power-up");

  AST_STANDBY_CS: assert property ((!prog_mode && cs_s) |=> (standby && !data_oe))  // [RULE_12]
    else $error("chip select high did not give standby with data floating");

  AST_GUARD_IGNORED: assert property ((read_step && !at_max) |=> data_oe)  // [RULE_10]
    else $error("read step did not drive data");

  AST_DSEL_GATES: assert property (  // [RULE_16]
      (state_reg == ST_PROG && prog_mode && !sync2_reg[`SCBR_SY_DSEL] && !reset_lvl) |=> $stable(addr_reg))
    else $error("counter moved in program mode without device select");

  AST_CASCADE_HIGH: assert property (  // [RULE_15]
      (state_reg != ST_EXHAUSTED && state_next != ST_EXHAUSTED) |=> cascade_out_low)
    else $error("cascade-out low before array exhausted");
endmodule : scbr_reader

`default_nettype wire

// >>> scbr_fpga_model.sv
`default_nettype none
module scbr_fpga_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic       data_out,
  input  wire logic       data_oe,
  output var  logic       fpga_config_clock,
  output var  logic       busy,
  output var  logic [7:0] captured
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] half_reg;
  logic [1:0] phase_reg;
  assign busy = (half_reg != 9'h000);
  // Clock rests low between frames; each phase lasts 4 clk
  always_ff @(posedge clk) begin
    if (rst) begin
      half_reg          <= 9'h000;
      phase_reg         <= 2'h0;
      fpga_config_clock <= 1'b0;
    end else if (start) begin
      half_reg  <= {pulses, 1'b0};
      phase_reg <= 2'h0;
    end else if (busy) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) begin
        half_reg          <= half_reg - 9'h001;
        fpga_config_clock <= ~fpga_config_clock;
      end
    end
  end
  // Sample on each rise; a floating line reads as the inverse of the last bit
  always_ff @(posedge clk) begin
    if (rst) begin
      captured <= 8'h00;
    end else if (busy && phase_reg == 2'h3 && !fpga_config_clock) begin
      captured <= {captured[6:0], data_oe ? data_out : ~captured[0]};
    end
  end
endmodule : scbr_fpga_model
`default_nettype wire

// >>> serial_config_bitstream_reader_bench.sv
`default_nettype none
module serial_config_bitstream_reader_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import scbr_pkg::*;
  typedef struct packed {
    logic        pol_low, cs_n, roe, guard;
    logic [15:0] idx;
    logic        oe, sb;
  } scbr_row_s;
  localparam scbr_row_s ROWS [6] = '{
    '{1'b1, 1'b0, 1'b1, 1'b1, 16'h0005, 1'b1, 1'b0},
    '{1'b1, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b1},
    '{1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0},
    '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1},
    '{1'b0, 1'b0, 1'b0, 1'b0, 16'h0005, 1'b1, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0}
  };
  logic       clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cs_n = 1'b1, roe = 1'b1, psel_n = 1'b1;
  logic       g1 = 1'b0, g2 = 1'b0, dsel = 1'b0, din = 1'b0, start = 1'b0;
  logic [7:0] npulse = 8'h00, cap;
  logic [7:0] pat = 8'hA6;
  scbr_pol_t  pol = 32'hFFFF_FFFF;
  logic       data_out, data_oe, cascade_out_low, ready_out, ready_oe, standby, fcclk, busy;
  scbr_addr_t bit_index;
  int         miscompares = 0, compares = 0;
  always #12.5 clk = ~clk;
  scbr_reader scbr_reader_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .fpga_config_clock(fcclk),
    .chip_sel_n(cs_n), .reset_oe(roe), .program_mode_select_n(psel_n), .block_guard_first(g1),
    .block_guard_second(g2), .device_select_bit(dsel), .polarity_bytes(pol), .data_in(din),
    .data_out(data_out), .data_oe(data_oe), .cascade_out_low(cascade_out_low), .ready_out(ready_out),
    .ready_oe(ready_oe), .standby(standby), .bit_index(bit_index));
  scbr_fpga_model scbr_fpga_model_inst (.clk(clk), .rst(rst), .start(start), .pulses(npulse),
    .data_out(data_out), .data_oe(data_oe), .fpga_config_clock(fcclk), .busy(busy), .captured(cap));
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] n);
    int k;
    start  <= 1'b1;
    npulse <= n;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 2000 && busy === 1'b1; k++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  initial begin
    scbr_row_s r;
    int        i;
    int        pass;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("ready_oe", 16'h0001, {15'h0000, ready_oe});
    chk("bit_index", 16'h0000, bit_index);
    repeat (45) @(posedge clk);
    #1;
    chk("ready_oe", 16'h0000, {15'h0000, ready_oe});
    chk("ready_out", 16'h0000, {15'h0000, ready_out});
    for (i = 0; i < 6; i++) begin
      r = ROWS[i];
      @(posedge clk);
      pol  <= r.pol_low ? 32'hFFFF_FFFF : 32'h0000_0000;
      roe  <= ~r.pol_low;
      cs_n <= 1'b0;
      repeat (8) @(posedge clk);
      cs_n <= r.cs_n;
      roe  <= r.roe;
      g1   <= r.guard;
      g2   <= r.guard;
      repeat (8) @(posedge clk);
      pulse(8'h05);
      #1;
      chk("bit_index", r.idx, bit_index);
      chk("data_oe", {15'h0000, r.oe}, {15'h0000, data_oe});
      chk("standby", {15'h0000, r.sb}, {15'h0000, standby});
    end
    @(posedge clk);
    pol    <= 32'hFFFF_FFFF;
    roe    <= 1'b1;
    psel_n <= 1'b0;
    cs_n   <= 1'b1;
    g1     <= 1'b0;
    g2     <= 1'b0;
    dsel   <= 1'b0;
    repeat (8) @(posedge clk);
    pulse(8'h03);
    #1;
    chk("bit_index", 16'h0000, bit_index);
    for (pass = 0; pass < 2; pass++) begin
      @(posedge clk);
      roe  <= 1'b0;
      dsel <= 1'b1;
      g1   <= pass[0];
      repeat (4) @(posedge clk);
      roe <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 7; i >= 0; i--) begin
        din <= pat[i] ^ pass[0];
        pulse(8'h01);
      end
      #1;
      chk("bit_index", 16'h0008, bit_index);
    end
    @(posedge clk);
    psel_n <= 1'b1;
    roe    <= 1'b0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b0;
    roe  <= 1'b1;
    repeat (8) @(posedge clk);
    pulse(8'h08);
    #1;
    chk("captured", {8'h00, pat}, {8'h00, cap});
    chk("bit_index", 16'h0008, bit_index);
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(8'h02);
    #1;
    chk("bit_index", 16'h0008, bit_index);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    @(posedge clk);
    cs_n <= 1'b1;
    roe  <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("bit_index", 16'h0000, bit_index);
    chk("cascade_out_low", 16'h0001, {15'h0000, cascade_out_low});
    complete_run;
  end
endmodule : serial_config_bitstream_reader_bench
`default_nettype wire
